// ===== hw/ext_ctrl_pkg.sv
package ext_ctrl_pkg;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RES_OFS    = 8'h04;
  localparam logic [7:0] SETPT_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] EVENT_OFS  = 8'h10;

  // Control register fields
  localparam int CTRL_SEL_LSB    = 0;  // 2 bits: external control select
  localparam int CTRL_POL_BIT    = 2;  // load-on input polarity
  localparam int CTRL_RANGE_LSB  = 3;  // 2 bits: front-panel range
  localparam int CTRL_TRGEN_BIT  = 5;  // trigger output enable
  localparam int CTRL_SHORT_BIT  = 6;  // short function active
  localparam int CTRL_MODE_LSB   = 8;  // 2 bits: operating mode

  // Event register bits (write-one pulses)
  localparam int EV_KEY_ON_BIT  = 0;
  localparam int EV_KEY_OFF_BIT = 1;
  localparam int EV_DYN_BIT     = 2;
  localparam int EV_SEQ_BIT     = 3;
  localparam int EV_PAUSE_BIT   = 4;

  // Status register fields
  localparam int ST_LOAD_BIT   = 0;
  localparam int ST_ALARM_BIT  = 1;
  localparam int ST_OVR_BIT    = 2;
  localparam int ST_PAUSED_BIT = 3;
  localparam int ST_RANGE_LSB  = 4;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] RES_RESET  = 16'h0000;

  // Resistance in ohms; full scale 10 k, over-range above 11.8 k
  localparam logic [15:0] RES_FULL_OHM = 16'd10000;
  localparam logic [15:0] RES_OVR_OHM  = 16'd11800;
  localparam int          SETPT_W      = 16;
  localparam logic [SETPT_W-1:0] SETPT_RATED = 16'hFFFF;

  // Timing
  localparam int CLK_MHZ       = 200;
  localparam int TRIG_IN_NS    = 10000;  // 10 us minimum trigger in
  localparam int TRIGGER_OUTPUT_ENABLE_NS   = 2000;   // 2 us minimum trigger out
  localparam int TRIG_IN_CYC   = (TRIG_IN_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIGGER_OUTPUT_ENABLE_CYC  = (TRIGGER_OUTPUT_ENABLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SEL_PANEL,
    SEL_VOLT,
    SEL_RPROP,
    SEL_RINV
  } ext_sel_e;

  typedef enum logic [1:0] {
    RANGE_HIGH,
    RANGE_MID,
    RANGE_LOW
  } current_range_setting_e;

  typedef enum logic [1:0] {
    constant_current_mode,
    constant_resistance_mode,
    constant_voltage_mode,
    constant_power_mode
  } op_mode_e;

endpackage

// ===== hw/ext_control_pin_logic.sv
`timescale 1ns/1ps
// Contract
// [R1] Resistance above 11.8k raises over-range alarm and zeroes set-point.
// [R2] Resistance control works identically in all four operating modes.
// [R3] Proportional set-point is rated times resistance in kilohms over ten.
// [R4] Inverse set-point is rated times one minus kilohms over ten.
// [R5] Control select picks proportional or inverse resistance control.
// [R6] Load turns on when load-on input matches configured polarity.
// [R7] External input holding load off blocks panel key turn-on.
// [R8] Panel key may still turn off an externally enabled load.
// [R9] Load status output shows whether load is on.
// [R10] External range select only with voltage or resistance control.
// [R11] External range select only when panel range is high.
// [R12] Range inputs: HH high, first high second low middle, LH low.
// [R13] Range status: high off-off, middle off-on, low on-off.
// [R14] Trigger input pulse resumes a paused sequence.
// [R15] Outside party drives active-high trigger of at least 10 us.
// [R16] Low alarm input raises alarm and message; high clears it.
// [R17] External device or parallel slave may pull alarm input low.
// [R18] Alarm status output shows whether alarm is on.
// [R19] Short relay closes only while short function is active.
// [R20] Trigger out on dynamic switching, and on sequence when enabled.
// [R21] Trigger output pulse lasts at least 2 us.
// [R22] Inverse control recommended so an open cable gives minimum.
// [R23] All external inputs pass a two-stage synchroniser first.
// [R24] Trigger in counts after staying high minimum width, once per pulse.
module ext_control_pin_logic
  import ext_ctrl_pkg::*;
#(
  parameter int TRIG_IN_CYCLES  = TRIG_IN_CYC,
  parameter int TRIGGER_OUTPUT_ENABLE_CYCLES = TRIGGER_OUTPUT_ENABLE_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               load_on_in,
  input  wire logic               range_sel1_in,
  input  wire logic               range_sel2_in,
  input  wire logic               trig_in,
  input  wire logic               alarm_in_n,
  output logic                    load_status,
  output logic                    range_status1,
  output logic                    range_status0,
  output logic                    alarm_status,
  output logic                    short_relay,
  output logic                    trigger_output_enable,
  output logic                    ext_overrange_alarm,
  output logic                    ext_alarm_message,
  output logic                    seq_resume,
  output logic      [SETPT_W-1:0] setpoint
);

  localparam int TIW = $clog2(TRIG_IN_CYCLES + 1);
  localparam int TOW = $clog2(TRIGGER_OUTPUT_ENABLE_CYCLES + 1);
  localparam logic [TIW-1:0] TI_MAX = TIW'(TRIG_IN_CYCLES);
  localparam logic [TOW-1:0] TO_MAX = TOW'(TRIGGER_OUTPUT_ENABLE_CYCLES);

  typedef enum logic [1:0] {
    TRG_IDLE,
    TRG_COUNT,
    TRG_WAIT_LOW
  } trg_state_e;

  typedef struct packed {
    logic [4:0]         s1;
    logic [4:0]         s2;
    logic [31:0]        ctrl;
    logic [15:0]        res;
    logic               load_on;
    logic               ext_on_prev;
    logic               paused;
    current_range_setting_e            range;
    trg_state_e         trg;
    logic [TIW-1:0]     ti_cnt;
    logic [TOW-1:0]     to_cnt;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               load_status;
    logic               rs1;
    logic               rs0;
    logic               alarm;
    logic               short_relay;
    logic               trigger_output_enable;
    logic               ovr;
    logic               resume;
    logic [SETPT_W-1:0] setpoint;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [4:0] raw_in;
  assign raw_in = {alarm_in_n, trig_in, range_sel2_in, range_sel1_in,
                   load_on_in};

  always_comb begin
    ext_sel_e   sel;
    logic       ext_on;
    logic       wr;
    logic [7:0] ev;
    logic [31:0] prod;
    logic [15:0] r_eff;
    current_range_setting_e    ext_rng;
    logic       ext_rng_ok;
    logic       trig_fire;
    sel        = ext_sel_e'(st_q.ctrl[CTRL_SEL_LSB +: 2]);
    ext_on     = 1'b0;
    wr         = 1'b0;
    ev         = 8'h00;
    prod       = 32'h0000_0000;
    r_eff      = 16'h0000;
    ext_rng    = RANGE_HIGH;
    ext_rng_ok = 1'b0;
    trig_fire  = 1'b0;
    st_d       = st_q;

    // Synchroniser stage two reads only stage one
    st_d.s1 = raw_in;  // [R23]
    st_d.s2 = st_q.s1;  // [R23]

    // APB: one wait state, answer in the second access cycle after setup
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.resume  = 1'b0;
    if (psel && penable && !st_q.pready) begin
      st_d.pready = 1'b1;
      wr = pwrite;
      st_d.prdata = 32'h0000_0000;
      case (paddr)
        CTRL_OFS: begin
          if (wr) st_d.ctrl = pwdata;
          st_d.prdata = st_q.ctrl;
        end
        RES_OFS: begin
          if (wr) st_d.res = pwdata[15:0];
          st_d.prdata = {16'h0000, st_q.res};
        end
        SETPT_OFS: st_d.prdata = {{(32-SETPT_W){1'b0}}, st_q.setpoint};
        STATUS_OFS: st_d.prdata = {26'h0, st_q.range, st_q.paused,
                                   st_q.ovr, st_q.alarm, st_q.load_on};
        EVENT_OFS: if (wr) ev = pwdata[7:0];
        default: st_d.pslverr = 1'b1;
      endcase
    end

    // Load on/off from external input and panel key
    ext_on = (st_q.s2[0] == st_q.ctrl[CTRL_POL_BIT]);  // [R6]
    if (ext_on && !st_q.ext_on_prev) st_d.load_on = 1'b1;  // [R6]
    else if (!ext_on && st_q.ext_on_prev) st_d.load_on = 1'b0;  // [R6]
    if (ev[EV_KEY_OFF_BIT]) st_d.load_on = 1'b0;  // [R8]
    else if (ev[EV_KEY_ON_BIT] && ext_on) st_d.load_on = 1'b1;  // [R7]
    if (!ext_on) st_d.load_on = 1'b0;  // [R7]
    st_d.ext_on_prev = ext_on;
    st_d.load_status = st_d.load_on;  // [R9]

    // Range: external decode only under V/R/Rinv and panel high
    case ({st_q.s2[1], st_q.s2[2]})
      2'b11: ext_rng = RANGE_HIGH;  // [R12]
      2'b10: ext_rng = RANGE_MID;  // [R12]
      2'b01: ext_rng = RANGE_LOW;  // [R12]
      default: ext_rng = RANGE_HIGH;
    endcase
    ext_rng_ok = (sel != SEL_PANEL)  // [R10]
               && (current_range_setting_e'(st_q.ctrl[CTRL_RANGE_LSB +: 2])
                   == RANGE_HIGH);  // [R11]
    st_d.range = ext_rng_ok ? ext_rng
               : current_range_setting_e'(st_q.ctrl[CTRL_RANGE_LSB +: 2]);
    st_d.rs1 = (st_d.range == RANGE_LOW);  // [R13]
    st_d.rs0 = (st_d.range == RANGE_MID);  // [R13]

    // Alarm follows the active-low input level
    st_d.alarm = !st_q.s2[4];  // [R16] [R18]

    st_d.short_relay = st_q.ctrl[CTRL_SHORT_BIT];  // [R19]

    // Set-point, mode independent
    st_d.ovr = (sel == SEL_RPROP || sel == SEL_RINV)
             && (st_q.res > RES_OVR_OHM);  // [R1]
    r_eff = (st_q.res > RES_FULL_OHM) ? RES_FULL_OHM : st_q.res;
    if (sel == SEL_RINV)
      r_eff = RES_FULL_OHM - r_eff;  // [R4]
    prod = 32'(SETPT_RATED) * 32'(r_eff);  // [R3] [R2]
    if (st_d.ovr)
      st_d.setpoint = '0;  // [R1]
    else if (sel == SEL_RPROP || sel == SEL_RINV)  // [R5]
      st_d.setpoint = SETPT_W'(prod / 32'(RES_FULL_OHM));
    else
      st_d.setpoint = '0;

    // Trigger input qualifier
    case (st_q.trg)
      TRG_IDLE: begin
        st_d.ti_cnt = '0;
        if (st_q.s2[3]) st_d.trg = TRG_COUNT;
      end
      TRG_COUNT: begin
        if (!st_q.s2[3]) st_d.trg = TRG_IDLE;
        else if (st_q.ti_cnt >= TI_MAX - 1'b1) begin
          st_d.trg = TRG_WAIT_LOW;  // [R24]
          trig_fire = 1'b1;  // [R24]
        end else st_d.ti_cnt = st_q.ti_cnt + 1'b1;
      end
      TRG_WAIT_LOW: if (!st_q.s2[3]) st_d.trg = TRG_IDLE;  // [R24]
      default: st_d.trg = TRG_IDLE;
    endcase

    // Pause wins nothing over a simultaneous resume
    if (ev[EV_PAUSE_BIT]) st_d.paused = 1'b1;
    if (trig_fire && st_q.paused) begin
      st_d.paused = 1'b0;  // [R14]
      st_d.resume = 1'b1;  // [R14]
    end

    // Trigger output pulse, retriggerable
    if (ev[EV_DYN_BIT]
        || (ev[EV_SEQ_BIT] && st_q.ctrl[CTRL_TRGEN_BIT])) begin  // [R20]
      st_d.to_cnt = TO_MAX;  // [R21]
    end else if (st_q.to_cnt != '0) begin
      st_d.to_cnt = st_q.to_cnt - 1'b1;
    end
    st_d.trigger_output_enable = (st_d.to_cnt != '0);  // [R21]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= '0;
      st_q.s1   <= 5'h11;
      st_q.s2   <= 5'h11;
      st_q.ctrl <= CTRL_RESET;
      st_q.res  <= RES_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign prdata              = st_q.prdata;
  assign pready              = st_q.pready;
  assign pslverr             = st_q.pslverr;
  assign load_status         = st_q.load_status;
  assign range_status1       = st_q.rs1;
  assign range_status0       = st_q.rs0;
  assign alarm_status        = st_q.alarm;
  assign short_relay         = st_q.short_relay;
  assign trigger_output_enable            = st_q.trigger_output_enable;
  assign ext_overrange_alarm = st_q.ovr;
  assign ext_alarm_message   = st_q.alarm;
  assign seq_resume          = st_q.resume;
  assign setpoint            = st_q.setpoint;

endmodule

// ===== dv/ext_control_pin_logic_props.sv
`timescale 1ns/1ps
module ext_ctrl_checker
  import ext_ctrl_pkg::*;
#(
  parameter int TRIG_IN_CYCLES  = 8,
  parameter int TRIGGER_OUTPUT_ENABLE_CYCLES = 4
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               trig_in,
  input wire logic               alarm_in_n,
  input wire logic               alarm_status,
  input wire logic               ext_alarm_message,
  input wire logic               range_status1,
  input wire logic               range_status0,
  input wire logic               trigger_output_enable,
  input wire logic               seq_resume,
  input wire logic               ext_overrange_alarm,
  input wire logic [SETPT_W-1:0] setpoint
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int   tc_q;
  int   hi_q;
  logic tp_q;
  // Length of the latest trigger-in run, kept after it ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_q <= 0;
      hi_q <= 0;
      tp_q <= 1'b0;
    end else begin
      tp_q <= trig_in;
      tc_q <= !trig_in ? tc_q : (tp_q ? tc_q + 1 : 1);
      hi_q <= trigger_output_enable ? hi_q + 1 : 0;
    end
  end
  sequence apb_req;
    psel && penable && !pready;
  endsequence
  alarm_pin_a:
    assert property (alarm_status == !$past(alarm_in_n, 3))
    else $error("alarm status does not follow its input");
  alarm_msg_a:
    assert property (ext_alarm_message == alarm_status)
    else $error("alarm message differs from alarm status");
  range_code_a:
    assert property (!(range_status1 && range_status0))
    else $error("range status shows an unused code");
  ovr_zero_a:
    assert property (ext_overrange_alarm && $past(ext_overrange_alarm)
                     |-> setpoint == '0)
    else $error("set-point not zero during over-range");
  trig_width_a:
    assert property ($fell(trigger_output_enable) |-> hi_q >= TRIGGER_OUTPUT_ENABLE_CYCLES)
    else $error("trigger output pulse too short");
  resume_once_a:
    assert property (seq_resume |=> !seq_resume)
    else $error("resume pulse longer than one cycle");
  resume_cause_a:
    assert property (seq_resume |-> tc_q >= TRIG_IN_CYCLES)
    else $error("resume without a long enough trigger");
  apb_answer_a:
    assert property (apb_req |=> pready)
    else $error("access not answered in the next cycle");
endmodule
bind ext_control_pin_logic ext_ctrl_checker #(
  .TRIG_IN_CYCLES (TRIG_IN_CYCLES),
  .TRIGGER_OUTPUT_ENABLE_CYCLES(TRIGGER_OUTPUT_ENABLE_CYCLES)
) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .trig_in(trig_in), .alarm_in_n(alarm_in_n),
  .alarm_status(alarm_status), .ext_alarm_message(ext_alarm_message),
  .range_status1(range_status1), .range_status0(range_status0),
  .trigger_output_enable(trigger_output_enable), .seq_resume(seq_resume),
  .ext_overrange_alarm(ext_overrange_alarm), .setpoint(setpoint));

// ===== dv/ext_party_model.sv
`timescale 1ns/1ps
module ext_party_model (
  input  wire logic pclk,
  output logic      load_on_in,
  output logic      range_sel1_in,
  output logic      range_sel2_in,
  output logic      trig_in,
  output logic      alarm_in_n
);
  // Open switches: pulled-up pins high, trigger pulled low
  initial begin
    load_on_in    = 1'h1;
    range_sel1_in = 1'h1;
    range_sel2_in = 1'h1;
    trig_in       = 1'h0;
    alarm_in_n    = 1'h1;
  end
  // Load-on, range and alarm pins; alarm pulled low by a controller or parallel slave
  task automatic pins(input logic l, s1, s2, a_n);
    @(posedge pclk);
    load_on_in    <= l;
    range_sel1_in <= s1;
    range_sel2_in <= s2;
    alarm_in_n    <= a_n;
  endtask
  // Active-high trigger pulse of n cycles
  task automatic pulse(input int n);
    @(posedge pclk);
    trig_in <= 1'h1;
    repeat (n) @(posedge pclk);
    trig_in <= 1'h0;
  endtask
endmodule

// ===== dv/tb_ext_control_pin_logic.sv
`timescale 1ns/1ps
module tb_ext_control_pin_logic
  import ext_ctrl_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, ld, r1, r2, tin, aln, lst, rs1, rs0;
  logic ast, srl, tout, ovr, amsg, sres, ce = 1;
  logic [SETPT_W-1:0] setpoint;
  int fail_count = 0, total_checks = 0, rc = 0, tc = 0, r0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (sres === 1'h1) rc++;
    if (tout === 1'h1) tc++;
  end
  ext_control_pin_logic #(.TRIG_IN_CYCLES(8), .TRIGGER_OUTPUT_ENABLE_CYCLES(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_on_in(ld),
    .range_sel1_in(r1), .range_sel2_in(r2), .trig_in(tin),
    .alarm_in_n(aln), .load_status(lst), .range_status1(rs1),
    .range_status0(rs0), .alarm_status(ast), .short_relay(srl),
    .trigger_output_enable(tout), .ext_overrange_alarm(ovr),
    .ext_alarm_message(amsg), .seq_resume(sres), .setpoint(setpoint));
  ext_party_model i_party (.pclk(pclk), .load_on_in(ld),
    .range_sel1_in(r1), .range_sel2_in(r2), .trig_in(tin),
    .alarm_in_n(aln));
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic t_regs;
    apb(0, CTRL_OFS, 0); chk(q, CTRL_RESET);
    apb(0, 8'h20, 0); chk(e, 1'h1); chk(q, 32'h0);
  endtask
  task automatic t_setpt;
    for (int m = 0; m < 4; m++) begin
      apb(1, CTRL_OFS, 32'h2 | (m << 8)); apb(1, RES_OFS, 32'h9C4);
      w(4); chk(setpoint, 16'h3FFF);
    end
    apb(1, CTRL_OFS, 32'h3); w(4); chk(setpoint, 16'hBFFF);
    apb(0, SETPT_OFS, 0); chk(q, 32'hBFFF);
    apb(1, CTRL_OFS, 32'h2); apb(1, RES_OFS, 32'h2E18); w(4);
    chk(ovr, 1'h0); chk(setpoint, 16'hFFFF);
    apb(1, RES_OFS, 32'h2E19); w(4); chk(ovr, 1'h1);
    apb(1, RES_OFS, 32'h9C4); w(4); chk(ovr, 1'h0);
    // Open cable reads as huge resistance: inverse must give minimum
    apb(1, CTRL_OFS, 32'h3); apb(1, RES_OFS, 32'hFFFF); w(4);
    chk(setpoint, 16'h0000);
    apb(1, RES_OFS, 32'h9C4);
  endtask
  task automatic t_freeze;
    apb(1, EVENT_OFS, 32'h4);
    ce <= 1'h0;
    w(10); chk(tout, 1'h1);
    ce <= 1'h1;
    w(10); chk(tout, 1'h0);
  endtask
  task automatic t_load;
    apb(1, CTRL_OFS, 32'h4); i_party.pins(0, 1, 1, 1); w(5);
    chk(lst, 1'h0);
    i_party.pins(1, 1, 1, 1); w(5); chk(lst, 1'h1);
    apb(1, EVENT_OFS, 32'h2); w(2); chk(lst, 1'h0);
    apb(1, EVENT_OFS, 32'h1); w(2); chk(lst, 1'h1);
    i_party.pins(0, 1, 1, 1); w(5); chk(lst, 1'h0);
    apb(1, EVENT_OFS, 32'h1); w(2); chk(lst, 1'h0);
    apb(1, CTRL_OFS, 32'h0); i_party.pins(1, 1, 1, 1); w(5);
    i_party.pins(0, 1, 1, 1); w(5); chk(lst, 1'h1);
  endtask
  task automatic t_range;
    logic [3:0] tb[3] = '{4'hC, 4'h9, 4'h6};
    apb(1, CTRL_OFS, 32'h1);
    foreach (tb[i]) begin
      i_party.pins(1, tb[i][3], tb[i][2], 1); w(5);
      chk({rs1, rs0}, tb[i][1:0]);
    end
    apb(1, CTRL_OFS, 32'h9); w(3); chk({rs1, rs0}, 2'h1);
    apb(1, CTRL_OFS, 32'h0); w(3); chk({rs1, rs0}, 2'h0);
  endtask
  task automatic t_pins;
    i_party.pins(1, 1, 1, 0); w(5); chk({ast, amsg}, 2'h3);
    i_party.pins(1, 1, 1, 1); w(5); chk({ast, amsg}, 2'h0);
    apb(1, EVENT_OFS, 32'h10); apb(0, STATUS_OFS, 0); chk(q[3], 1'h1);
    r0 = rc;
    i_party.pulse(3); w(20); chk(rc, r0);
    i_party.pulse(12); w(20); chk(rc, r0 + 1);
    apb(0, STATUS_OFS, 0); chk(q[3], 1'h0);
    i_party.pulse(12); w(20); chk(rc, r0 + 1);
  endtask
  task automatic t_outs;
    r0 = tc;
    apb(1, EVENT_OFS, 32'h4); w(10); chk(tc, r0 + 4);
    apb(1, EVENT_OFS, 32'h8); w(10); chk(tc, r0 + 4);
    apb(1, CTRL_OFS, 32'h20); apb(1, EVENT_OFS, 32'h8); w(10);
    chk(tc, r0 + 8);
    apb(1, CTRL_OFS, 32'h40); w(2); chk(srl, 1'h1);
    apb(1, CTRL_OFS, 32'h0); w(2); chk(srl, 1'h0);
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    w(20);
    presetn <= 1'h1;
    w(2);
    t_regs;
    t_setpt;
    t_load;
    t_range;
    t_pins;
    t_outs;
    t_freeze;
    finish_test;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
endmodule
